/* File: design/flash_seq_pkg.sv */
// Shared opcodes, frame counts and timing constants of the flash command sequencer.
package flash_seq_pkg;

  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SUSPEND_LATENCY_NS = 20000;
  localparam int SUSPEND_LATENCY_CYC_I = (SUSPEND_LATENCY_NS / CLK_PERIOD_NS < 1) ? 1 :
                                         SUSPEND_LATENCY_NS / CLK_PERIOD_NS;
  localparam logic [31:0] SUSPEND_LATENCY_CYC = 32'(SUSPEND_LATENCY_CYC_I);

  // ********************************************************************
  // Opcodes
  // ********************************************************************
  localparam logic [7:0] OPC_WRITE_EN = 8'h06;
  localparam logic [7:0] OPC_WRITE_DIS = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS1 = 8'h05;
  localparam logic [7:0] OPC_READ_STATUS2 = 8'h35;
  localparam logic [7:0] OPC_ARRAY_ERASE_A = 8'hc7;
  localparam logic [7:0] OPC_ARRAY_ERASE_B = 8'h60;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7a;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;
  localparam logic [7:0] OPC_DTR_FAST_READ = 8'h0d;
  localparam logic [7:0] OPC_SET_READ_PARAM = 8'hc0;
  localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OPC_RESET = 8'h99;

  // ********************************************************************
  // Frame counts in rising clock edges
  // ********************************************************************
  localparam logic [11:0] OPC_BITS = 12'h008;
  localparam logic [11:0] PARAM_END_CNT = 12'h010;
  localparam logic [11:0] DTR_ADDR_END_CNT = 12'h014;
  localparam logic [11:0] ADDR_END_CNT = 12'h020;
  localparam logic [11:0] PROG_MIN_CNT = 12'h028;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam logic [11:0] DUMMY_SPI_CNT = 12'h008;
  localparam logic [11:0] DUMMY_DTR_CNT = 12'h006;
  localparam logic [11:0] DUMMY_4_CNT = 12'h004;
  localparam logic [11:0] DUMMY_6_CNT = 12'h006;
  localparam logic [11:0] DUMMY_8_CNT = 12'h008;

  // ********************************************************************
  // Storage, fields and reset values
  // ********************************************************************
  localparam int MEM_DEPTH = 16;
  localparam int MEM_IDX_W = 4;
  localparam int SECTOR_LSB = 12;
  localparam int PARAM_LSB = 4;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [1:0] READ_PARAM_RESET = 2'h0;

  typedef enum logic [1:0] {OP_NONE, OP_ARRAY_ERASE, OP_RANGE_ERASE, OP_PROGRAM} op_kind_e;

  // Code 2'h3 is reserved and falls back to the longest setting.
  function automatic logic [11:0] dummy_clocks(input logic [1:0] p);
    unique case (p)
      2'h0: dummy_clocks = DUMMY_4_CNT;
      2'h1: dummy_clocks = DUMMY_6_CNT;
      2'h2: dummy_clocks = DUMMY_8_CNT;
      default: dummy_clocks = DUMMY_8_CNT;
    endcase
  endfunction : dummy_clocks

endpackage : flash_seq_pkg

/* File: design/bit_sync.sv */
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
  input wire logic clk,
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q <= meta_r;
  end
endmodule : bit_sync
`default_nettype wire

/* File: design/dtr_out_cell.sv */
// Serial output stage holding one bit per falling edge for single rate reads and one bit per clock edge for double rate reads.
`timescale 1ns/1ps
`default_nettype none
module dtr_out_cell (
  input wire logic linkClk,
  input wire logic csN,
  input wire logic dtrSel,
  input wire logic riseLoad,
  input wire logic riseBit,
  input wire logic fallLoad,
  input wire logic fallBit,
  output logic serialOut,
  output logic serialOutEn
);
  logic riseQ_r;
  logic fallQ_r;
  logic en_r;

  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      riseQ_r <= 1'b0;
    end else if (riseLoad) begin
      riseQ_r <= riseBit;
    end
  end

  always_ff @(negedge linkClk or posedge csN) begin
    if (csN) begin
      fallQ_r <= 1'b0;
      en_r <= 1'b0;
    end else begin
      if (fallLoad) begin
        fallQ_r <= fallBit;
      end
      en_r <= en_r | fallLoad;
    end
  end

  // In double rate the high phase shows the bit taken at the rising edge.
  assign serialOut = (dtrSel && linkClk) ? riseQ_r : fallQ_r;
  assign serialOutEn = en_r;
endmodule : dtr_out_cell
`default_nettype wire

/* File: design/serial_flash_seq.sv */
// Serial flash command sequencer: array erase, suspend/resume and read paths.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_seq
  import flash_seq_pkg::*;
#(
  parameter int ARRAY_ERASE_CYC = 5000000,
  parameter int RANGE_ERASE_CYC = 50000,
  parameter int PROGRAM_CYC = 10000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic serialInLine,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic fourLineCommandMode,
  input wire logic sectorGranularityProtect,
  input wire logic topBottomProtect,
  input wire logic [2:0] protectField,
  output logic busy,
  output logic writeLatchFlag,
  output logic suspendStatus
);

  // ********************************************************************
  // Decoding helpers
  // ********************************************************************
  function automatic logic isArrayErase(input logic [7:0] o);
    isArrayErase = (o == OPC_ARRAY_ERASE_A) || (o == OPC_ARRAY_ERASE_B);
  endfunction : isArrayErase

  function automatic logic isRangeErase(input logic [7:0] o);
    isRangeErase = (o == OPC_SECTOR_ERASE) || (o == OPC_HALF_BLOCK_ERASE) ||
                   (o == OPC_BLOCK_ERASE);
  endfunction : isRangeErase

  function automatic logic isDtr(input logic [7:0] o);
    isDtr = (o == OPC_DTR_FAST_READ);
  endfunction : isDtr

  // Captured frame contents, written on the link clock and read by the system side.
  logic [7:0] opc_r;
  logic [11:0] cnt_r;
  logic [23:0] addr_r;
  logic [7:0] dataIn_r;

  // ********************************************************************
  // System side: frame end detection
  // ********************************************************************
  logic csSync;
  logic csPrev_r;
  logic frameEnd;

  bit_sync uCsSync (
    .clk(clk_sys),
    .d(csN),
    .q(csSync)
  );

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      csPrev_r <= 1'b1;
    end else begin
      csPrev_r <= csSync;
    end
  end

  // The link clock stands still once select is high, so the captured frame is stable here.
  assign frameEnd = csSync && !csPrev_r;

  // ********************************************************************
  // System side: command acceptance
  // ********************************************************************
  logic busy_r;
  logic wel_r;
  logic sus_r;
  logic resetArm_r;
  logic [1:0] readParam_r;
  op_kind_e opKind_r;
  op_kind_e parkKind_r;
  logic [31:0] opTimer_r;
  logic [31:0] parkTimer_r;
  logic [31:0] susCnt_r;
  logic [23:0] opAddr_r;
  logic [23:0] parkAddr_r;
  logic [7:0] opData_r;
  logic [7:0] parkData_r;
  logic [7:0] mem_r [MEM_DEPTH];

  logic exact8;
  logic suspending;
  logic progParked;
  logic parkedSectorHit;
  logic startArray;
  logic startRange;
  logic startProg;
  logic acceptSuspend;
  logic acceptResume;
  logic opDone;

  assign exact8 = frameEnd && (cnt_r == OPC_BITS);
  assign suspending = (susCnt_r != 32'h0);
  assign progParked = sus_r && (parkKind_r == OP_PROGRAM);
  assign parkedSectorHit = sus_r && (addr_r[23:SECTOR_LSB] == parkAddr_r[23:SECTOR_LSB]);

  assign startArray = exact8 && isArrayErase(opc_r) && wel_r && !busy_r && !sus_r &&
                      (protectField == 3'h0);
  assign startRange = frameEnd && (cnt_r == ADDR_END_CNT) && isRangeErase(opc_r) &&
                      wel_r && !busy_r && !sus_r;
  assign startProg = frameEnd && (opc_r == OPC_PAGE_PROG) && (cnt_r >= PROG_MIN_CNT) &&
                     (cnt_r[2:0] == 3'h0) && wel_r && !busy_r &&
                     !progParked && !parkedSectorHit;
  assign acceptSuspend = exact8 && (opc_r == OPC_SUSPEND) && busy_r && !sus_r &&
                         ((opKind_r == OP_RANGE_ERASE) || (opKind_r == OP_PROGRAM));
  assign acceptResume = exact8 && (opc_r == OPC_RESUME) && sus_r && !busy_r;
  assign opDone = busy_r && !suspending && (opTimer_r == 32'h0);

  // ********************************************************************
  // System side: self-timed operation and its suspension
  // ********************************************************************
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      opKind_r <= OP_NONE;
      parkKind_r <= OP_NONE;
      opTimer_r <= 32'h0;
      parkTimer_r <= 32'h0;
      susCnt_r <= 32'h0;
      opAddr_r <= 24'h0;
      parkAddr_r <= 24'h0;
      opData_r <= ERASED_BYTE;
      parkData_r <= ERASED_BYTE;
    end else if (startArray) begin
      busy_r <= 1'b1;
      opKind_r <= OP_ARRAY_ERASE;
      opTimer_r <= 32'(ARRAY_ERASE_CYC);
    end else if (startRange) begin
      busy_r <= 1'b1;
      opKind_r <= OP_RANGE_ERASE;
      opTimer_r <= 32'(RANGE_ERASE_CYC);
      opAddr_r <= addr_r;
    end else if (startProg) begin
      busy_r <= 1'b1;
      opKind_r <= OP_PROGRAM;
      opTimer_r <= 32'(PROGRAM_CYC);
      opAddr_r <= addr_r;
      opData_r <= dataIn_r;
    end else if (acceptSuspend) begin
      susCnt_r <= SUSPEND_LATENCY_CYC;
    end else if (acceptResume) begin
      busy_r <= 1'b1;
      opKind_r <= parkKind_r;
      opTimer_r <= parkTimer_r;
      opAddr_r <= parkAddr_r;
      opData_r <= parkData_r;
      parkKind_r <= OP_NONE;
    end else if (suspending) begin
      // The paused operation is parked so a program may run inside an erase suspension.
      susCnt_r <= susCnt_r - 32'h1;
      if (susCnt_r == 32'h1) begin
        busy_r <= 1'b0;
        parkKind_r <= opKind_r;
        parkTimer_r <= opTimer_r;
        parkAddr_r <= opAddr_r;
        parkData_r <= opData_r;
        opKind_r <= OP_NONE;
      end
    end else if (opDone) begin
      busy_r <= 1'b0;
      opKind_r <= OP_NONE;
    end else if (busy_r) begin
      opTimer_r <= opTimer_r - 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sus_r <= 1'b0;
    end else if (acceptSuspend) begin
      sus_r <= 1'b1;
    end else if (acceptResume) begin
      sus_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wel_r <= 1'b0;
    end else if (opDone) begin
      wel_r <= 1'b0;
    end else if (exact8 && !busy_r && (opc_r == OPC_WRITE_EN)) begin
      wel_r <= 1'b1;
    end else if (exact8 && !busy_r && (opc_r == OPC_WRITE_DIS)) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      readParam_r <= READ_PARAM_RESET;
      resetArm_r <= 1'b0;
    end else if (frameEnd) begin
      resetArm_r <= exact8 && (opc_r == OPC_RESET_ENABLE);
      if (exact8 && resetArm_r && (opc_r == OPC_RESET)) begin
        readParam_r <= READ_PARAM_RESET;
      end else if ((opc_r == OPC_SET_READ_PARAM) && (cnt_r == PARAM_END_CNT)) begin
        readParam_r <= dataIn_r[PARAM_LSB +: 2];
      end
    end
  end

  // The model array is small and aliases every address onto its low index bits.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else if (opDone) begin
      if ((opKind_r == OP_ARRAY_ERASE) || (opKind_r == OP_RANGE_ERASE)) begin
        for (int i = 0; i < MEM_DEPTH; i++) begin
          mem_r[i] <= ERASED_BYTE;
        end
      end else if (opKind_r == OP_PROGRAM) begin
        mem_r[opAddr_r[MEM_IDX_W-1:0]] <= mem_r[opAddr_r[MEM_IDX_W-1:0]] & opData_r;
      end
    end
  end

  assign busy = busy_r;
  assign writeLatchFlag = wel_r;
  assign suspendStatus = sus_r;

  // ********************************************************************
  // Link side: status levels brought onto the link clock
  // ********************************************************************
  localparam int LVL_W = 11;
  logic [LVL_W-1:0] sysLvl;
  logic [LVL_W-1:0] lnkLvl;
  logic lBusy;
  logic lFour;
  logic [1:0] lParam;
  logic [7:0] status1;
  logic [7:0] status2;

  assign sysLvl = {fourLineCommandMode, readParam_r, sectorGranularityProtect,
                   topBottomProtect, protectField, wel_r, busy_r, sus_r};

  for (genvar gi = 0; gi < LVL_W; gi++) begin : gLvlSync
    bit_sync uLvl (
      .clk(linkClk),
      .d(sysLvl[gi]),
      .q(lnkLvl[gi])
    );
  end

  assign lFour = lnkLvl[10];
  assign lParam = lnkLvl[9:8];
  assign lBusy = lnkLvl[1];
  assign status1 = {1'b0, lnkLvl[7:1]};
  assign status2 = {lnkLvl[0], 7'h0};

  // ********************************************************************
  // Link side: frame capture
  // ********************************************************************
  logic first_r;
  logic [11:0] cntNxt;
  logic [11:0] riseAddr_r;
  logic [11:0] fallAddr_r;
  logic [23:0] dtrAddr;
  logic [23:0] readBase;

  always_ff @(posedge linkClk or posedge csN) begin
    if (csN) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  assign cntNxt = first_r ? 12'h001 : ((cnt_r == CNT_MAX) ? cnt_r : cnt_r + 12'h001);

  always_ff @(posedge linkClk) begin
    cnt_r <= cntNxt;
    if (cntNxt <= OPC_BITS) begin
      opc_r <= {opc_r[6:0], serialInLine};
    end
  end

  always_ff @(posedge linkClk) begin
    if (!isDtr(opc_r) && (cntNxt > OPC_BITS) && (cntNxt <= ADDR_END_CNT)) begin
      addr_r <= {addr_r[22:0], serialInLine};
    end
    if (isDtr(opc_r) && (cntNxt > OPC_BITS) && (cntNxt <= DTR_ADDR_END_CNT)) begin
      riseAddr_r <= {riseAddr_r[10:0], serialInLine};
    end
  end

  always_ff @(posedge linkClk) begin
    if (((opc_r == OPC_SET_READ_PARAM) && (cntNxt > OPC_BITS) && (cntNxt <= PARAM_END_CNT)) ||
        ((opc_r == OPC_PAGE_PROG) && (cntNxt > ADDR_END_CNT) && (cntNxt <= PROG_MIN_CNT))) begin
      dataIn_r <= {dataIn_r[6:0], serialInLine};
    end
  end

  always_ff @(negedge linkClk) begin
    if (isDtr(opc_r) && (cnt_r > OPC_BITS) && (cnt_r <= DTR_ADDR_END_CNT)) begin
      fallAddr_r <= {fallAddr_r[10:0], serialInLine};
    end
  end

  always_comb begin
    dtrAddr = 24'h0;
    for (int i = 0; i < 12; i++) begin
      dtrAddr[23 - 2 * i] = riseAddr_r[11 - i];
      dtrAddr[22 - 2 * i] = fallAddr_r[11 - i];
    end
  end

  assign readBase = isDtr(opc_r) ? dtrAddr : addr_r;

  // ********************************************************************
  // Link side: read output
  // ********************************************************************
  logic outAllowed;
  logic statusSel;
  logic [11:0] outStart;
  logic [11:0] fallK;
  logic [11:0] riseK;
  logic [11:0] riseDiff;
  logic fallLoad;
  logic riseLoad;

  // Array words change only while busy, and reads are refused then, so no crossing is needed.
  function automatic logic pickBit(input logic [11:0] k);
    logic [MEM_IDX_W-1:0] idx;
    idx = readBase[MEM_IDX_W-1:0] + k[MEM_IDX_W+2:3];
    if (statusSel) begin
      pickBit = (opc_r == OPC_READ_STATUS1) ? status1[~k[2:0]] : status2[~k[2:0]];
    end else begin
      pickBit = mem_r[idx][~k[2:0]];
    end
  endfunction : pickBit

  always_comb begin
    outAllowed = 1'b0;
    statusSel = 1'b0;
    outStart = CNT_MAX;
    case (opc_r)
      OPC_READ_STATUS1, OPC_READ_STATUS2: begin
        outAllowed = 1'b1;
        statusSel = 1'b1;
        outStart = OPC_BITS;
      end
      OPC_READ: begin
        outAllowed = !lBusy;
        outStart = ADDR_END_CNT;
      end
      OPC_FAST_READ: begin
        outAllowed = !lBusy;
        outStart = ADDR_END_CNT + (lFour ? dummy_clocks(lParam) : DUMMY_SPI_CNT);
      end
      OPC_DTR_FAST_READ: begin
        outAllowed = !lBusy;
        outStart = DTR_ADDR_END_CNT + DUMMY_DTR_CNT;
      end
      default: begin
        outAllowed = 1'b0;
      end
    endcase
  end

  assign fallLoad = outAllowed && (cnt_r >= outStart);
  assign riseLoad = outAllowed && isDtr(opc_r) && (cntNxt > outStart);
  assign riseDiff = cntNxt - outStart - 12'h001;
  assign fallK = isDtr(opc_r) ? {cnt_r[10:0] - outStart[10:0], 1'b0} : cnt_r - outStart;
  assign riseK = {riseDiff[10:0], 1'b1};

  dtr_out_cell uOut (
    .linkClk(linkClk),
    .csN(csN),
    .dtrSel(isDtr(opc_r)),
    .riseLoad(riseLoad),
    .riseBit(pickBit(riseK)),
    .fallLoad(fallLoad),
    .fallBit(pickBit(fallK)),
    .serialOut(serialOut),
    .serialOutEn(serialOutEn)
  );

endmodule : serial_flash_seq
`default_nettype wire

/* File: verif/serial_flash_seq_asserts.sv */
// Concurrent checks on the status outputs and the serial output enable of the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_seq_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic csN,
  input wire logic serialOutEn,
  input wire logic busy,
  input wire logic writeLatchFlag,
  input wire logic suspendStatus
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_new_op_latch: assert property ($rose(busy) && !$past(suspendStatus) |-> writeLatchFlag)
    else $error("operation started without write latch");
  chk_latch_idle: assert property ($rose(writeLatchFlag) |-> !$past(busy))
    else $error("write latch set while busy");
  chk_suspend_now: assert property ($rose(suspendStatus) |-> busy ##1 busy [*7])
    else $error("busy dropped at once on suspend");
  chk_suspend_latency: assert property ($rose(suspendStatus) |-> ##[1:510] !busy)
    else $error("busy not cleared within suspend latency");
  chk_resume_busy: assert property ($fell(suspendStatus) |-> busy)
    else $error("resume did not raise busy");
  chk_resume_idle: assert property ($fell(suspendStatus) |-> !$past(busy))
    else $error("resume accepted while busy");
  chk_end_latch: assert property ($fell(busy) && !suspendStatus |-> !writeLatchFlag)
    else $error("write latch left set at operation end");
  chk_out_frame: assert property (serialOutEn |-> !csN)
    else $error("output driven outside a frame");
endmodule : serial_flash_seq_asserts

bind serial_flash_seq serial_flash_seq_asserts chk_u (.clk_sys(clk_sys), .nrst(nrst),
  .csN(csN), .serialOutEn(serialOutEn), .busy(busy), .writeLatchFlag(writeLatchFlag),
  .suspendStatus(suspendStatus));
`default_nettype wire

/* File: verif/flash_host_model.sv */
// Behavioural host controller that frames commands on the serial link.
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  output var logic linkClk,
  output var logic csN,
  output var logic serialInLine,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    serialInLine = 1'b0;
  end

  // The clock idles low between frames; after the command bits the input toggles so
  // that a device which wrongly samples it sees changing junk, not a settled value.
  task automatic xfer(input logic [39:0] tx, input int nb, input int nd, input int nr,
                      output logic [15:0] rx, output logic en);
    rx = '0;
    en = 1'b0;
    csN = 1'b0;
    for (int i = 0; i < nb + nd + nr; i++) begin
      serialInLine = (i < nb) ? tx[nb - 1 - i] : ~serialInLine;
      if (i >= nb + nd) begin
        rx = {rx[14:0], serialOut};
        en = en | serialOutEn;
      end
      #16 linkClk = 1'b1;
      #32 linkClk = 1'b0;
      #16;
    end
    csN = 1'b1;
    serialInLine = ~serialInLine;
    #200;
  endtask : xfer

  // Double rate read: address bits go in on both edges and data comes back on both,
  // the fall bit in the low phase and the rise bit in the high phase.
  task automatic xfer_dtr(input logic [31:0] tx, input int nr, output logic [15:0] rx);
    rx = '0;
    csN = 1'b0;
    for (int i = 0; i < 26 + nr; i++) begin
      serialInLine = (i < 8) ? tx[31 - i] : (i < 20) ? tx[39 - 2 * i] : ~serialInLine;
      if (i >= 26) begin
        rx = {rx[14:0], serialOut};
      end
      #16 linkClk = 1'b1;
      #16;
      if (i >= 8 && i < 20) begin
        serialInLine = tx[38 - 2 * i];
      end else if (i >= 26) begin
        rx = {rx[14:0], serialOut};
      end
      #16 linkClk = 1'b0;
      #16;
    end
    csN = 1'b1;
    serialInLine = ~serialInLine;
    #200;
  endtask : xfer_dtr
endmodule : flash_host_model
`default_nettype wire

/* File: verif/serial_flash_seq_bench.sv */
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_seq_bench import flash_seq_pkg::*; ;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic fourLineCommandMode = 1'b0;
  logic sectorGranularityProtect = 1'b0;
  logic topBottomProtect = 1'b0;
  logic [2:0] protectField = 3'h0;
  logic linkClk, csN, serialInLine, serialOut, serialOutEn;
  logic busy, writeLatchFlag, suspendStatus;
  logic [15:0] rx;
  logic en;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int dn[5] = '{4, 4, 6, 8, 8};

  // Program time outlasts a whole read frame, so the refused read cannot straddle its end.
  serial_flash_seq #(.ARRAY_ERASE_CYC(200), .RANGE_ERASE_CYC(100), .PROGRAM_CYC(100)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .linkClk(linkClk), .csN(csN),
    .serialInLine(serialInLine), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .fourLineCommandMode(fourLineCommandMode),
    .sectorGranularityProtect(sectorGranularityProtect),
    .topBottomProtect(topBottomProtect), .protectField(protectField), .busy(busy),
    .writeLatchFlag(writeLatchFlag), .suspendStatus(suspendStatus));

  flash_host_model host_u (.linkClk(linkClk), .csN(csN), .serialInLine(serialInLine),
    .serialOut(serialOut), .serialOutEn(serialOutEn));

  // ****************
  // Shared tasks
  // ****************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Status is sampled at a falling edge so it never races the update edge.
  task automatic stat(input logic [2:0] e);
    @(negedge clk_sys);
    check({13'h0, suspendStatus, writeLatchFlag, busy}, {13'h0, e});
  endtask : stat

  task automatic cmd(input logic [39:0] tx, input int nb);
    host_u.xfer(tx, nb, 0, 0, rx, en);
  endtask : cmd

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int nd, input int nr);
    host_u.xfer({8'h00, op, a}, 32, nd, nr, rx, en);
  endtask : rd

  task automatic wait_idle;
    int i;
    i = 0;
    @(negedge clk_sys);
    while (busy !== 1'b0 && i < 4000) begin
      @(negedge clk_sys);
      i++;
    end
  endtask : wait_idle

  // ****************
  // Clock and timeout
  // ****************
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    stat(3'h0);
    cmd(OPC_WRITE_EN, 8);
    stat(3'h2);
    cmd({OPC_PAGE_PROG, 24'h000005, 8'h5a}, 40);
    stat(3'h3);
    rd(OPC_READ, 24'h000005, 0, 16);
    check({15'h0, en}, 16'h0000);
    wait_idle();
    stat(3'h0);
    rd(OPC_READ, 24'h000004, 0, 16);
    check(rx, {ERASED_BYTE, 8'h5a});
    rd(OPC_FAST_READ, 24'h000005, 8, 16);
    check(rx, {8'h5a, ERASED_BYTE});
    host_u.xfer_dtr({OPC_DTR_FAST_READ, 24'h000004}, 8, rx);
    check(rx, {ERASED_BYTE, 8'h5a});
    $display("program and read test done");
    @(posedge clk_sys);
    fourLineCommandMode <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      if (k > 0) cmd({OPC_SET_READ_PARAM, 2'h0, 2'(k - 1), 4'h0}, 16);
      rd(OPC_FAST_READ, 24'h000005, dn[k], 8);
      check(rx, 16'h005a);
    end
    cmd(OPC_RESET_ENABLE, 8);
    cmd(OPC_RESET, 8);
    rd(OPC_FAST_READ, 24'h000005, 4, 8);
    check(rx, 16'h005a);
    @(posedge clk_sys);
    fourLineCommandMode <= 1'b0;
    $display("dummy count test done");
    cmd(OPC_ARRAY_ERASE_A, 8);
    stat(3'h0);
    @(posedge clk_sys);
    protectField <= 3'h1;
    cmd(OPC_WRITE_EN, 8);
    cmd(OPC_ARRAY_ERASE_B, 8);
    stat(3'h2);
    @(posedge clk_sys);
    protectField <= 3'h0;
    sectorGranularityProtect <= 1'b1;
    topBottomProtect <= 1'b1;
    cmd({OPC_ARRAY_ERASE_A, 1'b0}, 9);
    stat(3'h2);
    cmd(OPC_ARRAY_ERASE_A, 8);
    stat(3'h3);
    host_u.xfer(OPC_READ_STATUS1, 8, 0, 8, rx, en);
    check(rx, 16'h0063);
    cmd(OPC_SUSPEND, 8);
    stat(3'h3);
    wait_idle();
    stat(3'h0);
    rd(OPC_READ, 24'h000005, 0, 8);
    check(rx, {8'h00, ERASED_BYTE});
    $display("array erase test done");
    cmd(OPC_SUSPEND, 8);
    stat(3'h0);
    cmd(OPC_WRITE_EN, 8);
    cmd({OPC_SECTOR_ERASE, 24'h000000}, 32);
    cmd(OPC_SUSPEND, 8);
    stat(3'h7);
    cmd(OPC_RESUME, 8);
    stat(3'h7);
    wait_idle();
    stat(3'h6);
    host_u.xfer(OPC_READ_STATUS2, 8, 0, 8, rx, en);
    check(rx, 16'h0080);
    cmd(OPC_ARRAY_ERASE_A, 8);
    stat(3'h6);
    cmd({OPC_BLOCK_ERASE, 24'h010000}, 32);
    stat(3'h6);
    cmd({OPC_PAGE_PROG, 24'h000003, 8'h00}, 40);
    stat(3'h6);
    cmd(OPC_RESUME, 8);
    stat(3'h3);
    wait_idle();
    stat(3'h0);
    $display("erase suspend test done");
    cmd(OPC_WRITE_EN, 8);
    cmd({OPC_PAGE_PROG, 24'h001002, 8'h0f}, 40);
    cmd(OPC_SUSPEND, 8);
    wait_idle();
    cmd({OPC_PAGE_PROG, 24'h002002, 8'h00}, 40);
    stat(3'h6);
    cmd(OPC_RESUME, 8);
    wait_idle();
    rd(OPC_READ, 24'h000002, 0, 8);
    check(rx, 16'h000f);
    $display("program suspend test done");
    cmd(OPC_WRITE_EN, 8);
    cmd({OPC_PAGE_PROG, 24'h000007, 8'h00}, 40);
    cmd(OPC_SUSPEND, 8);
    stat(3'h7);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    stat(3'h0);
    $display("reset in suspension test done");
    end_sim();
  end
endmodule : serial_flash_seq_bench
`default_nettype wire
